// ===== rtl/iem_pkg.sv
// constants, states and helpers of the serial memory byte master
// assumes: user logic on a 50 MHz clock, bus engine on a separate link clock
package iem_pkg;

  // ----------------------------------------------------------------
  // clock and bus timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20; // user-side clock period
  localparam int LINK_PERIOD_PS = 15000; // link clock period
  localparam int STD_BIT_NS = 10000; // 100 kbit/s bit time
  localparam int FAST_BIT_NS = 2500; // 400 kbit/s bit time
  localparam int QTR_W = 8; // width of the quarter-bit counter
  // a quarter bit is a least time, so round up: the rate never exceeds the limit
  localparam logic [QTR_W-1:0] STD_QTR_CYC = QTR_W'((STD_BIT_NS * 1000 / 4 + LINK_PERIOD_PS - 1) / LINK_PERIOD_PS);
  localparam logic [QTR_W-1:0] FAST_QTR_CYC = QTR_W'((FAST_BIT_NS * 1000 / 4 + LINK_PERIOD_PS - 1) / LINK_PERIOD_PS);
  // slave write time after the stop that ends a write
  localparam int WRITE_WAIT_NS = 5000000;
  localparam int WRITE_WAIT_CYC = (WRITE_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAIT_W = 18; // holds WRITE_WAIT_CYC

  // ----------------------------------------------------------------
  // frame layout
  // ----------------------------------------------------------------
  localparam logic [3:0] CTRL_CODE = 4'ha; // memory device-type code
  localparam logic RW_WRITE = 1'h0; // direction bit for a write
  localparam logic RW_READ = 1'h1; // direction bit for a read
  localparam logic [3:0] ACK_BIT = 4'h8; // bit index of the ninth pulse
  localparam logic [1:0] LAST_PHASE = 2'h3; // last quarter of a bit
  localparam logic [1:0] SDA_PHASE = 2'h1; // quarter where data may change

  // ----------------------------------------------------------------
  // state encodings
  // ----------------------------------------------------------------
  // gray along idle -> start -> byte -> restart -> stop
  typedef enum logic [2:0] {
    IEM_IDLE = 3'h0,
    IEM_START = 3'h1,
    IEM_BYTE = 3'h3,
    IEM_RESTART = 3'h2,
    IEM_STOP = 3'h6
  } iem_state_e;

  // which byte of the frame is on the wire
  typedef enum logic [2:0] {
    IEM_CTRL_W = 3'h0,
    IEM_ADDR_H = 3'h1,
    IEM_ADDR_L = 3'h3,
    IEM_WDATA = 3'h2,
    IEM_CTRL_R = 3'h6,
    IEM_RDATA = 3'h7
  } iem_stage_e;

  // control byte: type code, three select bits, direction
  function automatic logic [7:0] iem_ctrl_byte(input logic [2:0] sel, input logic rw);
    iem_ctrl_byte = {CTRL_CODE, sel, rw};
  endfunction : iem_ctrl_byte

endpackage : iem_pkg

// ===== rtl/iem_sync.sv
// two flip-flop synchroniser for levels entering a clock domain
// assumes: the reset input is synchronous to clk_i or tied low
`timescale 1ns/1ns
module iem_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  // ----------------------------------------------------------------
  // stages
  // ----------------------------------------------------------------
  logic [W-1:0] meta; // first stage, read only by the second

  // the first stage may go metastable; nothing but q_o looks at it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta <= RST_VAL;
      q_o <= RST_VAL;
    end else begin
      meta <= d_i;
      q_o <= meta;
    end
  end

endmodule : iem_sync

// ===== rtl/iem_div.sv
// quarter-bit tick generator for the serial clock
// assumes: fast_i is stable while a frame runs
`timescale 1ns/1ns
module iem_div
  import iem_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic fast_i,
  output logic tick_o
);

  // ----------------------------------------------------------------
  // divider
  // ----------------------------------------------------------------
  logic [QTR_W-1:0] cnt; // cycles into the current quarter
  logic [QTR_W-1:0] limit; // quarter length for the chosen mode

  // mode select keeps the bus at or below its rate limit
  assign limit = fast_i ? FAST_QTR_CYC : STD_QTR_CYC;

  // free-running count, one tick per quarter bit
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt <= '0;
      tick_o <= 1'h0;
    end else if (cnt >= limit - QTR_W'(1)) begin
      cnt <= '0;
      tick_o <= 1'h1;
    end else begin
      cnt <= cnt + QTR_W'(1);
      tick_o <= 1'h0;
    end
  end

endmodule : iem_div

// ===== rtl/iem_byte_master.sv
// two-wire bus master for single-byte writes and random reads of a serial memory
// assumes: open-drain pins with pull-ups outside; link_clk_i runs freely;
// one slave answers, no other master on the bus
//
// Contract
// - data changes only while clock low
// - start is data falling with clock high
// - stop is data rising with clock high
// - master alone makes start and stop
// - start only when both lines idle high
// - master makes every clock pulse
// - eight bits per byte, msb first
// - ninth pulse carries acknowledge, low means ack
// - first byte is control, code 1010
// - three select or high address bits
// - last control bit: 0 write, 1 read
// - one address byte, or high then low
// - sender releases data on ninth pulse, samples
// - master acknowledges read data bytes; the code leaves its single read byte unacknowledged
// - write sends one data byte after address
// - read: address, repeated start, read control
// - clock rate selectable, standard or fast
// - wait the write time after write stop
`timescale 1ns/1ns
module iem_byte_master
  import iem_pkg::*;
#(
  parameter int WRITE_WAIT = WRITE_WAIT_CYC
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic link_clk_i,
  input wire logic start_i,
  input wire logic read_i,
  input wire logic two_byte_i,
  input wire logic fast_i,
  input wire logic [2:0] dev_sel_i,
  input wire logic [15:0] mem_addr_i,
  input wire logic [7:0] wdata_i,
  output logic busy_o,
  output logic done_o,
  output logic nack_o,
  output logic [7:0] rdata_o,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_n_o,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n_o
);

  // ----------------------------------------------------------------
  // user side: command hold registers (clock_i)
  // ----------------------------------------------------------------
  logic cmd_rd; // frame is a random read
  logic cmd_two; // two address bytes
  logic cmd_fast; // fast mode rate
  logic [2:0] cmd_sel; // chip select bits
  logic [15:0] cmd_addr; // memory address
  logic [7:0] cmd_wdata; // byte to store
  logic req_tgl; // flips once per new frame
  logic ack_seen; // last link answer taken
  logic ack_sync; // link answer toggle, synchronised
  logic [WAIT_W-1:0] wait_cnt; // write time still to wait
  logic waiting; // slave busy storing the byte

  // link side state that the user side reads after the handshake
  logic ack_tgl; // flips when a frame has ended
  logic lk_nack; // slave left an acknowledge high
  logic [7:0] lk_rdata; // byte read from the memory

  // commands are held stable for the whole frame, so the link
  // side may read them directly once it has seen the toggle
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      cmd_rd <= 1'h0;
      cmd_two <= 1'h0;
      cmd_fast <= 1'h0;
      cmd_sel <= 3'h0;
      cmd_addr <= 16'h0;
      cmd_wdata <= 8'h0;
      req_tgl <= 1'h0;
    end else if (start_i && !busy_o) begin
      cmd_rd <= read_i;
      cmd_two <= two_byte_i;
      cmd_fast <= fast_i;
      cmd_sel <= dev_sel_i;
      cmd_addr <= mem_addr_i;
      cmd_wdata <= wdata_i;
      req_tgl <= !req_tgl;
    end
  end

  // answer toggle from the link domain
  iem_sync #(.W(1), .RST_VAL(1'h0)) u_ack_sync (
    .clk_i(clock_i),
    .rst_i(rst_i),
    .d_i(ack_tgl),
    .q_o(ack_sync)
  );

  // ----------------------------------------------------------------
  // user side: status and write-time wait
  // ----------------------------------------------------------------
  // busy covers the frame and, after a good write, the slave's write
  // time; a start while busy is ignored rather than queued
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      busy_o <= 1'h0;
      done_o <= 1'h0;
      nack_o <= 1'h0;
      rdata_o <= 8'h0;
      ack_seen <= 1'h0;
      waiting <= 1'h0;
      wait_cnt <= '0;
    end else begin
      done_o <= 1'h0;
      if (start_i && !busy_o) begin
        busy_o <= 1'h1;
      end else if (ack_sync != ack_seen) begin
        // link words settled at least four quarter bits before the toggle
        ack_seen <= ack_sync;
        done_o <= 1'h1;
        nack_o <= lk_nack;
        rdata_o <= lk_rdata;
        if (!cmd_rd && !lk_nack) begin
          waiting <= 1'h1;
          wait_cnt <= WAIT_W'(WRITE_WAIT - 1);
        end else begin
          busy_o <= 1'h0;
        end
      end else if (waiting) begin
        // no new frame reaches the slave until its write time is over
        if (wait_cnt == '0) begin
          waiting <= 1'h0;
          busy_o <= 1'h0;
        end else begin
          wait_cnt <= wait_cnt - WAIT_W'(1);
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // link side: reset, pin and request synchronisers (link_clk_i)
  // ----------------------------------------------------------------
  logic link_rst; // reset as seen by the link domain
  logic [1:0] pins; // {scl, sda} synchronised
  logic req_sync; // request toggle synchronised
  logic req_seen; // last request taken
  logic tick; // one quarter bit has passed
  logic scl_s; // synchronised clock line
  logic sda_s; // synchronised data line

  // reset asserts and releases on the link clock a little late
  iem_sync #(.W(1), .RST_VAL(1'h1)) u_rst_sync (
    .clk_i(link_clk_i),
    .rst_i(1'h0),
    .d_i(rst_i),
    .q_o(link_rst)
  );

  // the lines idle high, so they reset high
  iem_sync #(.W(2), .RST_VAL(2'h3)) u_pin_sync (
    .clk_i(link_clk_i),
    .rst_i(link_rst),
    .d_i({scl_i, sda_i}),
    .q_o(pins)
  );

  iem_sync #(.W(1), .RST_VAL(1'h0)) u_req_sync (
    .clk_i(link_clk_i),
    .rst_i(link_rst),
    .d_i(req_tgl),
    .q_o(req_sync)
  );

  assign scl_s = pins[1];
  assign sda_s = pins[0];

  // quarter-bit timing for the serial clock
  iem_div u_div (
    .clk_i(link_clk_i),
    .rst_i(link_rst),
    .fast_i(cmd_fast),
    .tick_o(tick)
  );

  // ----------------------------------------------------------------
  // link side: frame sequencing
  // ----------------------------------------------------------------
  iem_state_e state; // bus sequence state
  iem_stage_e stage; // byte now on the wire
  iem_stage_e next_stage; // byte that follows an acknowledged one
  logic [1:0] phase; // quarter within the bit or condition
  logic [3:0] bit_cnt; // 0..7 data bits, 8 acknowledge
  logic [7:0] shreg; // shift register, msb on the wire
  logic [7:0] next_byte; // value loaded for next_stage
  logic [2:0] sel_bits; // select or high address bits
  logic tx_stage; // master is the sender of this byte

  // small memories carry their top address bits in the control byte
  assign sel_bits = cmd_two ? cmd_sel : cmd_addr[10:8];
  assign tx_stage = (stage != IEM_RDATA);

  // order of bytes within a frame
  always_comb begin
    next_stage = IEM_CTRL_W;
    unique case (stage)
      IEM_CTRL_W: next_stage = cmd_two ? IEM_ADDR_H : IEM_ADDR_L;
      IEM_ADDR_H: next_stage = IEM_ADDR_L;
      IEM_ADDR_L: next_stage = cmd_rd ? IEM_CTRL_R : IEM_WDATA;
      IEM_WDATA: next_stage = IEM_WDATA;
      IEM_CTRL_R: next_stage = IEM_RDATA;
      IEM_RDATA: next_stage = IEM_RDATA;
      default: next_stage = IEM_CTRL_W;
    endcase
  end

  // byte to shift out for the following stage
  always_comb begin
    next_byte = 8'hff;
    unique case (next_stage)
      IEM_ADDR_H: next_byte = cmd_addr[15:8];
      IEM_ADDR_L: next_byte = cmd_addr[7:0];
      IEM_WDATA: next_byte = cmd_wdata;
      IEM_CTRL_R: next_byte = iem_ctrl_byte(sel_bits, RW_READ);
      IEM_RDATA: next_byte = 8'hff; // all ones keeps the line released
      default: next_byte = iem_ctrl_byte(sel_bits, RW_WRITE);
    endcase
  end

  // main sequencer, stepped once per quarter bit
  always_ff @(posedge link_clk_i) begin
    if (link_rst) begin
      state <= IEM_IDLE;
      stage <= IEM_CTRL_W;
      phase <= 2'h0;
      bit_cnt <= 4'h0;
      shreg <= 8'hff;
      req_seen <= 1'h0;
    end else if (tick) begin
      phase <= phase + 2'h1;
      unique case (state)
        IEM_IDLE: begin
          phase <= 2'h0;
          // a frame starts only on a free bus
          if (req_sync != req_seen && scl_s && sda_s) begin
            req_seen <= req_sync;
            state <= IEM_START;
          end
        end
        IEM_START: begin
          if (phase == LAST_PHASE) begin
            state <= IEM_BYTE;
            stage <= IEM_CTRL_W;
            bit_cnt <= 4'h0;
            shreg <= iem_ctrl_byte(sel_bits, RW_WRITE);
          end
        end
        IEM_BYTE: begin
          if (phase == LAST_PHASE) begin
            if (bit_cnt != ACK_BIT) begin
              // sample at the end of the high quarter, msb first
              shreg <= {shreg[6:0], sda_s};
              bit_cnt <= bit_cnt + 4'h1;
            end else if (tx_stage && sda_s) begin
              state <= IEM_STOP;
            end else if (stage == IEM_WDATA || stage == IEM_RDATA) begin
              state <= IEM_STOP;
            end else if (next_stage == IEM_CTRL_R) begin
              state <= IEM_RESTART;
              stage <= next_stage;
              shreg <= next_byte;
            end else begin
              stage <= next_stage;
              shreg <= next_byte;
              bit_cnt <= 4'h0;
            end
          end
        end
        IEM_RESTART: begin
          if (phase == LAST_PHASE) begin
            state <= IEM_BYTE;
            bit_cnt <= 4'h0;
          end
        end
        IEM_STOP: begin
          if (phase == LAST_PHASE) begin
            state <= IEM_IDLE;
          end
        end
        default: state <= IEM_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // link side: result and answer toggle
  // ----------------------------------------------------------------
  // results are written before the toggle flips, so the user side
  // sees settled words when it takes the answer
  always_ff @(posedge link_clk_i) begin
    if (link_rst) begin
      lk_nack <= 1'h0;
      lk_rdata <= 8'h0;
      ack_tgl <= 1'h0;
    end else if (tick && phase == LAST_PHASE) begin
      if (state == IEM_START) begin
        lk_nack <= 1'h0;
      end else if (state == IEM_BYTE && bit_cnt == ACK_BIT) begin
        // the sender looks at the line on the ninth pulse
        if (tx_stage && sda_s) begin
          lk_nack <= 1'h1;
        end
        if (stage == IEM_RDATA) begin
          lk_rdata <= shreg;
        end
      end else if (state == IEM_STOP) begin
        ack_tgl <= !ack_tgl;
      end
    end
  end

  // ----------------------------------------------------------------
  // link side: pin drive
  // ----------------------------------------------------------------
  logic next_scl_oe_n; // low pulls the clock line down
  logic next_sda_oe_n; // low pulls the data line down

  // the data line moves only in quarter 1 of a bit, well clear of
  // either clock edge; conditions move it while the clock is high
  always_comb begin
    next_scl_oe_n = 1'h1;
    next_sda_oe_n = sda_oe_n_o;
    unique case (state)
      IEM_IDLE: begin
        next_scl_oe_n = 1'h1;
        next_sda_oe_n = 1'h1;
      end
      IEM_START: begin
        next_scl_oe_n = (phase == LAST_PHASE) ? 1'h0 : 1'h1;
        next_sda_oe_n = (phase == 2'h0) ? 1'h1 : 1'h0;
      end
      IEM_BYTE: begin
        // master clocks the slave's bits and acknowledge as well
        next_scl_oe_n = phase[1];
        if (phase == SDA_PHASE) begin
          if (bit_cnt == ACK_BIT || !tx_stage) begin
            // release for the slave; the single read byte is left
            // unacknowledged so the slave stops sending
            next_sda_oe_n = 1'h1;
          end else begin
            next_sda_oe_n = shreg[7];
          end
        end
      end
      IEM_RESTART: begin
        next_scl_oe_n = phase[1];
        if (phase == SDA_PHASE) begin
          next_sda_oe_n = 1'h1;
        end else if (phase == LAST_PHASE) begin
          next_sda_oe_n = 1'h0;
        end
      end
      IEM_STOP: begin
        next_scl_oe_n = phase[1];
        if (phase == SDA_PHASE) begin
          next_sda_oe_n = 1'h0;
        end else if (phase == LAST_PHASE) begin
          next_sda_oe_n = 1'h1;
        end
      end
      default: begin
        next_scl_oe_n = 1'h1;
        next_sda_oe_n = 1'h1;
      end
    endcase
  end

  // open-drain outputs: the level is always low, the enable decides
  always_ff @(posedge link_clk_i) begin
    if (link_rst) begin
      scl_o <= 1'h0;
      sda_o <= 1'h0;
      scl_oe_n_o <= 1'h1;
      sda_oe_n_o <= 1'h1;
    end else begin
      scl_o <= 1'h0;
      sda_o <= 1'h0;
      scl_oe_n_o <= next_scl_oe_n;
      sda_oe_n_o <= next_sda_oe_n;
    end
  end

endmodule : iem_byte_master

// ===== verification/iem_asserts.sv
// checker for the byte master: pin timing and user handshake
// assumes: bound to iem_byte_master, rst_i synchronous to clock_i
`timescale 1ns/1ns
module iem_asserts
  import iem_pkg::*;
#(
  parameter int WRITE_WAIT = 20
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic link_clk_i,
  input wire logic start_i,
  input wire logic read_i,
  input wire logic busy_o,
  input wire logic done_o,
  input wire logic nack_o,
  input wire logic scl_i,
  input wire logic scl_oe_n_o,
  input wire logic sda_i,
  input wire logic sda_oe_n_o
);
  // ----------------------------------------------------------------
  // helper counters
  // ----------------------------------------------------------------
  logic prv_sda; // data enable one link cycle ago
  logic prv_scl; // clock enable one link cycle ago
  logic [7:0] pulses; // clock pulses since the last start
  logic [15:0] hi_cnt; // link cycles with the clock released
  logic [19:0] wait_cnt; // user cycles since the last done
  logic is_rd; // direction of the running request
  logic wr_ok; // last frame was an acknowledged write

  // pulse and high-time counting on the link side
  always_ff @(posedge link_clk_i) begin
    prv_sda <= rst_i | sda_oe_n_o;
    prv_scl <= rst_i | scl_oe_n_o;
    hi_cnt <= (scl_oe_n_o && !rst_i) ? hi_cnt + 16'h1 : 16'h0;
    if (rst_i || (prv_sda && !sda_oe_n_o && scl_oe_n_o)) begin
      pulses <= 8'h0;
    end else if (!prv_scl && scl_oe_n_o) begin
      pulses <= pulses + 8'h1;
    end
  end

  // request direction and write-wait timing on the user side
  always_ff @(posedge clock_i) begin
    if (start_i && !busy_o) begin
      is_rd <= read_i;
    end
    wait_cnt <= done_o ? 20'h0 : wait_cnt + 20'h1;
    wr_ok <= rst_i ? 1'b0 : (done_o ? (!nack_o && !is_rd) : wr_ok);
  end

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  property p_edge_apart;
    @(posedge link_clk_i) disable iff (rst_i) $changed(scl_oe_n_o) |-> $stable(sda_oe_n_o);
  endproperty
  a_edge_apart: assert property (p_edge_apart) else $error("data moved with a clock edge");
  property p_start;
    @(posedge link_clk_i) disable iff (rst_i)
      $fell(sda_oe_n_o) && scl_oe_n_o |=> !sda_oe_n_o throughout (##[1:340] $fell(scl_oe_n_o));
  endproperty
  a_start: assert property (p_start) else $error("start not held until clock low");
  property p_stop;
    @(posedge link_clk_i) disable iff (rst_i) $rose(sda_oe_n_o) && scl_oe_n_o |=> (sda_oe_n_o && scl_oe_n_o)[*8];
  endproperty
  a_stop: assert property (p_stop) else $error("bus not idle after stop");
  property p_free;
    @(posedge link_clk_i) disable iff (rst_i) $fell(sda_oe_n_o) && scl_oe_n_o |-> $past(sda_i) && $past(scl_i);
  endproperty
  a_free: assert property (p_free) else $error("start on a busy bus");
  property p_pulses;
    @(posedge link_clk_i) disable iff (rst_i) $rose(sda_oe_n_o) && scl_oe_n_o |-> pulses % 9 == 1;
  endproperty
  a_pulses: assert property (p_pulses) else $error("frame not whole nine-pulse bytes");
  property p_rate;
    @(posedge link_clk_i) disable iff (rst_i) $fell(scl_oe_n_o) |-> hi_cnt >= 16'(FAST_QTR_CYC);
  endproperty
  a_rate: assert property (p_rate) else $error("clock high too short");
  property p_take;
    @(posedge clock_i) disable iff (rst_i) start_i && !busy_o |=> busy_o ##0 !done_o;
  endproperty
  a_take: assert property (p_take) else $error("request not taken");
  property p_idle;
    @(posedge clock_i) disable iff (rst_i) !busy_o |-> scl_oe_n_o && sda_oe_n_o;
  endproperty
  a_idle: assert property (p_idle) else $error("lines driven while idle");
  property p_done_pulse;
    @(posedge clock_i) disable iff (rst_i) done_o |=> !done_o;
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done longer than one cycle");
  property p_nack_hold;
    @(posedge clock_i) disable iff (rst_i) !done_o |-> $stable(nack_o);
  endproperty
  a_nack_hold: assert property (p_nack_hold) else $error("nack changed without done");
  property p_nack_end;
    @(posedge clock_i) disable iff (rst_i) done_o && nack_o |=> !busy_o;
  endproperty
  a_nack_end: assert property (p_nack_end) else $error("busy held after abort");
  property p_write_wait;
    @(posedge clock_i) disable iff (rst_i)
      $fell(busy_o) && wr_ok && !done_o |-> wait_cnt >= WRITE_WAIT - 1 && wait_cnt <= WRITE_WAIT + 1;
  endproperty
  a_write_wait: assert property (p_write_wait) else $error("write time not kept");
endmodule : iem_asserts

bind iem_byte_master iem_asserts #(.WRITE_WAIT(WRITE_WAIT)) u_asserts (.clock_i(clock_i), .rst_i(rst_i),
  .link_clk_i(link_clk_i), .start_i(start_i), .read_i(read_i), .busy_o(busy_o), .done_o(done_o),
  .nack_o(nack_o), .scl_i(scl_i), .scl_oe_n_o(scl_oe_n_o), .sda_i(sda_i), .sda_oe_n_o(sda_oe_n_o));

// ===== verification/iem_slave_model.sv
// behavioural serial memory slave on the two-wire bus
// assumes: the bench resolves both wired lines with pull-ups
`timescale 1ns/1ns
module iem_slave_model (
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic nack_i,
  input wire logic [7:0] mem_i,
  output logic sda_oe_n_o
);
  logic [7:0] got[$]; // bytes received, cleared by the bench
  logic [7:0] sh; // receive shifter
  logic [7:0] txb; // byte being sent
  int cnt; // pulse index within the byte
  logic tx; // shifting data out
  logic tx_next; // send after this ninth pulse
  logic first; // next byte is the control byte
  initial begin
    sda_oe_n_o = 1'b1;
    cnt = 0;
    tx = 1'b0;
    tx_next = 1'b0;
    first = 1'b0;
  end
  // start or repeated start: a control byte follows
  always @(negedge sda_i) begin
    if (scl_i === 1'b1) begin
      cnt = 0;
      tx = 1'b0;
      tx_next = 1'b0;
      first = 1'b1;
    end
  end
  // sample on the rising clock, msb first; a master nack ends sending
  always @(posedge scl_i) begin
    if (cnt < 8 && !tx) begin
      sh = {sh[6:0], sda_i};
    end
    if (cnt == 8 && tx && sda_i) begin
      tx_next = 1'b0;
    end
    cnt = cnt + 1;
  end
  // change the line only while the clock is low
  always @(negedge scl_i) begin
    if (cnt == 8 && !tx) begin
      got.push_back(sh);
      tx_next = first && sh[0];
      first = 1'b0;
      sda_oe_n_o = nack_i;
    end else if (cnt == 8) begin
      sda_oe_n_o = 1'b1;
    end else begin
      if (cnt == 9) begin
        cnt = 0;
        tx = tx_next;
        txb = mem_i;
      end
      sda_oe_n_o = tx ? txb[7-cnt] : 1'b1;
    end
  end
endmodule : iem_slave_model

// ===== verification/i2c_eeprom_byte_master_test.sv
// self-checking bench: byte master against the slave model
// assumes: design, checker and slave model compiled first
`timescale 1ns/1ns
module i2c_eeprom_byte_master_test
  import iem_pkg::*;
;
  localparam int WAIT = 20; // short write time for simulation
  logic clock_i, rst_i, link_clk_i, start_i, read_i, two_byte_i, fast_i;
  logic [2:0] dev_sel_i;
  logic [15:0] mem_addr_i;
  logic [7:0] wdata_i, rdata_o, slv_mem;
  logic busy_o, done_o, nack_o, scl_oe_n_o, sda_oe_n_o, slv_oe_n, slv_nack;
  logic scl_w, sda_w, scl_lvl, sda_lvl;
  int errors = 0;
  int compares = 0;
  int cyc = 0;
  int seed;
  // wired lines with pull-ups
  assign scl_w = (scl_oe_n_o !== 1'b0) || (scl_lvl === 1'b1);
  assign sda_w = ((sda_oe_n_o !== 1'b0) || (sda_lvl === 1'b1)) && (slv_oe_n !== 1'b0);

  iem_byte_master #(.WRITE_WAIT(WAIT)) uut (.clock_i(clock_i), .rst_i(rst_i), .link_clk_i(link_clk_i),
    .start_i(start_i), .read_i(read_i), .two_byte_i(two_byte_i), .fast_i(fast_i), .dev_sel_i(dev_sel_i),
    .mem_addr_i(mem_addr_i), .wdata_i(wdata_i), .busy_o(busy_o), .done_o(done_o), .nack_o(nack_o),
    .rdata_o(rdata_o), .scl_i(scl_w), .scl_o(scl_lvl), .scl_oe_n_o(scl_oe_n_o), .sda_i(sda_w), .sda_o(sda_lvl),
    .sda_oe_n_o(sda_oe_n_o));
  iem_slave_model slave (.scl_i(scl_w), .sda_i(sda_w), .nack_i(slv_nack), .mem_i(slv_mem),
    .sda_oe_n_o(slv_oe_n));

  // ----------------------------------------------------------------
  // clocks and hang guard
  // ----------------------------------------------------------------
  initial begin
    clock_i = 1'b0;
    forever #10 clock_i = ~clock_i;
  end
  // 15 ns link clock, offset so its edges drift against the user clock
  initial begin
    link_clk_i = 1'b0;
    #3;
    forever begin
      #7 link_clk_i = ~link_clk_i;
      #8 link_clk_i = ~link_clk_i;
    end
  end
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 60000) begin
      errors++;
      end_of_test();
    end
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : check

  // one frame with random address and data; the expected bytes come from the frame layout
  task automatic run(input logic rd, input logic two, input logic fst, input logic nk);
    logic [7:0] ctl;
    logic [7:0] exp[$];
    int n;
    @(negedge clock_i);
    read_i = rd;
    two_byte_i = two;
    fast_i = fst;
    dev_sel_i = 3'($urandom);
    mem_addr_i = 16'($urandom);
    wdata_i = 8'($urandom);
    slv_mem = 8'($urandom);
    slv_nack = nk;
    slave.got.delete();
    ctl = {4'b1010, two ? dev_sel_i : mem_addr_i[10:8], 1'b0};
    exp.push_back(ctl);
    if (!nk) begin
      if (two) exp.push_back(mem_addr_i[15:8]);
      exp.push_back(mem_addr_i[7:0]);
      exp.push_back(rd ? (ctl | 8'h01) : wdata_i);
    end
    start_i = 1'b1;
    @(negedge clock_i);
    start_i = 1'b0;
    n = 0;
    while (done_o !== 1'b1 && n < 30000) begin
      @(negedge clock_i);
      n++;
    end
    check({7'h0, nack_o}, {7'h0, nk}, "nack");
    if (rd && !nk) check(rdata_o, slv_mem, "read data");
    check(8'(slave.got.size()), 8'(exp.size()), "byte count");
    foreach (exp[i]) check(slave.got[i], exp[i], "byte");
    while (busy_o !== 1'b0 && n < 30000) begin
      @(negedge clock_i);
      n++;
    end
    if (n >= 30000) begin
      errors++;
      $display("mismatch at %0t: frame never finished", $time);
    end
  endtask : run

  task automatic end_of_test();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_of_test

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    rst_i = 1'b1;
    start_i = 1'b0;
    read_i = 1'b0;
    two_byte_i = 1'b0;
    fast_i = 1'b0;
    dev_sel_i = 3'h0;
    mem_addr_i = 16'h0;
    wdata_i = 8'h0;
    slv_nack = 1'b0;
    slv_mem = 8'h0;
    seed = $urandom(32'h25f9dbbe);
    repeat (16) @(negedge clock_i);
    rst_i = 1'b0;
    repeat (8) @(negedge clock_i);
    run(1'b0, 1'b0, 1'b0, 1'b0);
    for (int i = 0; i < 4; i++) run(i[0], i[1], 1'b1, 1'b0);
    run(1'b0, 1'b1, 1'b1, 1'b1);
    run(1'b1, 1'b0, 1'b1, 1'b0);
    end_of_test();
  end
endmodule : i2c_eeprom_byte_master_test
